// >>> hw/supply_wakeup_map.svh
// Register offsets, field positions, reset values and counts of the block
`ifndef SUPPLY_WAKEUP_MAP_SVH
`define SUPPLY_WAKEUP_MAP_SVH
`define OFS_POWER_ONE      5'h00
`define OFS_POWER_TWO      5'h04
`define OFS_RESET_CAUSE    5'h08
`define OFS_PERIODIC       5'h0c
`define P1_DET_EN          0
`define P1_RST_EN          1
`define P1_IRQ_EN          2
`define P1_STOP_EN         3
`define P1_ACK             6
`define P1_FLAG            7
`define P2_DET_TRIP        0
`define P2_WARN_TRIP       1
`define P2_OSC_STOP        2
`define P2_RANGE           3
`define P2_KIND_LO         4
`define P2_KIND_HI         5
`define P2_WARN_FLAG       7
`define RC_LOW_SUPPLY      1
`define RC_POWER_ON        7
`define PT_SEL_LO          0
`define PT_SEL_HI          2
`define PT_IRQ_EN          4
`define PT_SRC_INT         5
`define PT_ACK             6
`define PT_FLAG            7
`define RST_DET_EN         1'b1
`define RST_RST_EN         1'b1
`define KIND_CLOCKED       2'h0
`define KIND_PARTIAL       2'h1
`define KIND_LOWEST        2'h2
`define INT_OSC_DIV        8'h32
`define PERIOD_BASE        16'h0008
`endif

// >>> hw/supply_wakeup_pkg.sv
// Types shared by the supply monitor and periodic wake-up timer
package supply_wakeup_pkg;
  typedef enum logic [2:0] {
    SEQ_POR_HOLD = 3'h1,
    SEQ_RUN      = 3'h2,
    SEQ_LV_HOLD  = 3'h4
  } seq_state_t;

  typedef enum logic [4:0] {
    MODE_RUN      = 5'h01,
    MODE_WAIT     = 5'h02,
    MODE_STOP_CLK = 5'h04,
    MODE_STOP_PRT = 5'h08,
    MODE_STOP_LOW = 5'h10
  } power_mode_t;
endpackage

// >>> hw/supply_wakeup_ctrl.sv
// Supply monitor, reset sequencer and periodic wake-up timer control
// Operation
// RULE1: Detector runs only when enabled; trip select picks high or low threshold.
// RULE2: Entering any stop mode turns detector off unless stop enable set.
// RULE3: Stop and detector enables both set refuse the two deepest stop modes.
// RULE4: Power-up or supply below power-on level holds reset until above low trip.
// RULE5: Power-on reset sets both power-on and low-voltage cause flags.
// RULE6: Reset enable set and low supply sensed generate a system reset.
// RULE7: After low-voltage reset, hold reset until supply above selected trip.
// RULE8: Low-voltage cause flag set after low-voltage reset and power-on reset.
// RULE9: Enabled detector without reset enable sets flag and raises interrupt.
// RULE10: Warning flag shows supply near detect level, never interrupts.
// RULE11: Warning trip select picks high or low warning threshold.
// RULE12: Timer raises events at a fixed multiple of source clock period.
// RULE13: Timer runs from external reference clock or internal oscillator.
// RULE14: Timer works in run, wait, partial and clocked stop, not lowest.
// RULE15: Run and wait modes use only the external reference clock.
// RULE16: Partial-power stop uses only the internal oscillator.
// RULE17: Clocked stop may use either external or internal source.
// RULE18: Software enables oscillator in stop with range zero for external use.
// RULE19: Timer register holds read-only flag, write-only ack, 3-bit period.
// RULE20: Local enable clear keeps timer events from reaching the CPU.
// RULE21: Period select zero gates the timer clock; no events then.
// RULE22: Writing one to ack clears flag; zero ignored; ack reads zero.
// RULE23: Flag set each period end; interrupt while flag and enable set.
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "supply_wakeup_map.svh"

module supply_wakeup_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        supply_por_ok,
  input  wire logic        below_detect_high,
  input  wire logic        below_detect_low,
  input  wire logic        below_warn_high,
  input  wire logic        below_warn_low,
  input  wire logic        external_reference_clock,
  input  wire logic        enter_wait,
  input  wire logic        enter_stop,
  input  wire logic        wake,
  output logic             system_reset,
  output logic             low_supply_irq,
  output logic             periodic_irq,
  output logic             detector_on,
  output logic             detector_high_trip,
  output logic             warning_high_trip,
  output logic      [4:0]  power_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address match, shared by read mux and write strobes
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  // Period length in source ticks, doubling per select step
  function automatic logic [15:0] period_ticks(input logic [2:0] s);
    logic [2:0] sh;
    sh = s - 3'h1;
    period_ticks = `PERIOD_BASE << sh;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  supply_wakeup_pkg::seq_state_t  seq_ff;
  supply_wakeup_pkg::seq_state_t  nxt_seq;
  supply_wakeup_pkg::power_mode_t mode_ff;

  logic        det_en_ff;
  logic        rst_en_ff;
  logic        irq_en_ff;
  logic        stop_en_ff;
  logic        low_flag_ff;
  logic        det_trip_ff;
  logic        warn_trip_ff;
  logic        osc_stop_ff;
  logic        range_ff;
  logic [1:0]  stop_kind_ff;
  logic        warn_flag_ff;
  logic        cause_por_ff;
  logic        cause_low_ff;
  logic [2:0]  period_sel_ff;
  logic        pt_irq_en_ff;
  logic        pt_src_int_ff;
  logic        pt_flag_ff;
  logic [7:0]  osc_div_ff;
  logic        int_tick_ff;
  logic [15:0] count_ff;

  logic        bus_go;
  logic        wr_go;
  logic        in_reset;
  logic        det_active;
  logic        below_sel;
  logic        low_hit;
  logic        lv_reset_hit;
  logic        src_tick;
  logic        timer_tick;
  logic        period_end;
  logic        wr_p1;
  logic        wr_p2;
  logic        wr_pt;
  logic [31:0] nxt_readdata;

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the request completes

  assign bus_go = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_go  = avs_write & ~avs_waitrequest;
  assign wr_p1  = wr_go & hit(avs_address, `OFS_POWER_ONE);
  assign wr_p2  = wr_go & hit(avs_address, `OFS_POWER_TWO);
  assign wr_pt  = wr_go & hit(avs_address, `OFS_PERIODIC);

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      avs_waitrequest <= 1'b1;
    else if ((avs_read | avs_write) & avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;

  // Read mux; acks read as zero, unmapped reads return zero
  always_comb
  begin
    nxt_readdata = 32'h0;
    if (hit(avs_address, `OFS_POWER_ONE))
    begin
      nxt_readdata[`P1_DET_EN]  = det_en_ff;
      nxt_readdata[`P1_RST_EN]  = rst_en_ff;
      nxt_readdata[`P1_IRQ_EN]  = irq_en_ff;
      nxt_readdata[`P1_STOP_EN] = stop_en_ff;
      nxt_readdata[`P1_FLAG]    = low_flag_ff;
    end
    else if (hit(avs_address, `OFS_POWER_TWO))
    begin
      nxt_readdata[`P2_DET_TRIP]  = det_trip_ff;
      nxt_readdata[`P2_WARN_TRIP] = warn_trip_ff;
      nxt_readdata[`P2_OSC_STOP]  = osc_stop_ff;
      nxt_readdata[`P2_RANGE]     = range_ff;
      nxt_readdata[`P2_KIND_HI:`P2_KIND_LO] = stop_kind_ff;
      nxt_readdata[`P2_WARN_FLAG] = warn_flag_ff;
    end
    else if (hit(avs_address, `OFS_RESET_CAUSE))
    begin
      nxt_readdata[`RC_POWER_ON]   = cause_por_ff;
      nxt_readdata[`RC_LOW_SUPPLY] = cause_low_ff;
    end
    else if (hit(avs_address, `OFS_PERIODIC))
    begin
      nxt_readdata[`PT_SEL_HI:`PT_SEL_LO] = period_sel_ff;  // RULE19
      nxt_readdata[`PT_IRQ_EN]  = pt_irq_en_ff;
      nxt_readdata[`PT_SRC_INT] = pt_src_int_ff;
      nxt_readdata[`PT_FLAG]    = pt_flag_ff;               // RULE22
    end
  end

  // Data is loaded one edge early so it stands when waitrequest is low
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      avs_readdata <= 32'h0;
    else if (avs_read & avs_waitrequest)
      avs_readdata <= nxt_readdata;

  ////////////////////////////////////////////////////////////////////////
  // Supply detection

  // Detector powers down in stop unless told to stay on
  assign det_active = det_en_ff &                                 // RULE1
                      ((mode_ff == supply_wakeup_pkg::MODE_RUN) |
                       (mode_ff == supply_wakeup_pkg::MODE_WAIT) |
                       stop_en_ff);                               // RULE2
  assign below_sel  = det_trip_ff ? below_detect_high
                                  : below_detect_low;             // RULE1
  assign low_hit      = det_active & below_sel;
  assign lv_reset_hit = low_hit & rst_en_ff &
                        (seq_ff == supply_wakeup_pkg::SEQ_RUN);   // RULE6
  assign in_reset     = (seq_ff != supply_wakeup_pkg::SEQ_RUN);

  // Reset sequencer; power-on loss overrides every other state
  always_comb
  begin
    nxt_seq = seq_ff;
    case (seq_ff)
      supply_wakeup_pkg::SEQ_POR_HOLD:
        if (supply_por_ok & ~below_detect_low)                  // RULE4
          nxt_seq = supply_wakeup_pkg::SEQ_RUN;
      supply_wakeup_pkg::SEQ_RUN:
        if (lv_reset_hit)
          nxt_seq = supply_wakeup_pkg::SEQ_LV_HOLD;
      supply_wakeup_pkg::SEQ_LV_HOLD:
        if (~below_sel)                                         // RULE7
          nxt_seq = supply_wakeup_pkg::SEQ_RUN;
      default:
        nxt_seq = supply_wakeup_pkg::SEQ_POR_HOLD;
    endcase
    if (~supply_por_ok)
      nxt_seq = supply_wakeup_pkg::SEQ_POR_HOLD;                // RULE4
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      seq_ff       <= supply_wakeup_pkg::SEQ_POR_HOLD;          // RULE4
      system_reset <= 1'b1;
    end
    else
    begin
      seq_ff       <= nxt_seq;
      system_reset <= (nxt_seq != supply_wakeup_pkg::SEQ_RUN);
    end

  // Reset cause: power-on sets both, low-voltage reset sets its own
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      cause_por_ff <= 1'b1;                                     // RULE5
      cause_low_ff <= 1'b1;                                     // RULE8
    end
    else if (~supply_por_ok)
    begin
      cause_por_ff <= 1'b1;                                     // RULE5
      cause_low_ff <= 1'b1;
    end
    else if (lv_reset_hit)
      cause_low_ff <= 1'b1;                                     // RULE8

  // Control bits of the first power register; reset hold restores them
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      det_en_ff  <= `RST_DET_EN;
      rst_en_ff  <= `RST_RST_EN;
      irq_en_ff  <= 1'b0;
      stop_en_ff <= 1'b0;
    end
    else if (in_reset)
    begin
      det_en_ff  <= `RST_DET_EN;
      rst_en_ff  <= `RST_RST_EN;
      irq_en_ff  <= 1'b0;
      stop_en_ff <= 1'b0;
    end
    else if (wr_p1)
    begin
      det_en_ff  <= avs_writedata[`P1_DET_EN];
      rst_en_ff  <= avs_writedata[`P1_RST_EN];
      irq_en_ff  <= avs_writedata[`P1_IRQ_EN];
      stop_en_ff <= avs_writedata[`P1_STOP_EN];
    end

  // Trip selects survive a low-voltage hold: it needs the chosen level
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      det_trip_ff  <= 1'b0;
      warn_trip_ff <= 1'b0;
    end
    else if (seq_ff == supply_wakeup_pkg::SEQ_POR_HOLD)
    begin
      det_trip_ff  <= 1'b0;
      warn_trip_ff <= 1'b0;
    end
    else if (wr_p2 & ~in_reset)
    begin
      det_trip_ff  <= avs_writedata[`P2_DET_TRIP];              // RULE1
      warn_trip_ff <= avs_writedata[`P2_WARN_TRIP];             // RULE11
    end

  // Other bits of the second power register
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      osc_stop_ff  <= 1'b0;
      range_ff     <= 1'b0;
      stop_kind_ff <= `KIND_CLOCKED;
    end
    else if (in_reset)
    begin
      osc_stop_ff  <= 1'b0;
      range_ff     <= 1'b0;
      stop_kind_ff <= `KIND_CLOCKED;
    end
    else if (wr_p2)
    begin
      osc_stop_ff  <= avs_writedata[`P2_OSC_STOP];
      range_ff     <= avs_writedata[`P2_RANGE];
      stop_kind_ff <= avs_writedata[`P2_KIND_HI:`P2_KIND_LO];
    end

  // Low-supply flag; a new event wins over a same-cycle ack
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      low_flag_ff <= 1'b0;
    else if (in_reset)
      low_flag_ff <= 1'b0;
    else if (low_hit & ~rst_en_ff)                              // RULE9
      low_flag_ff <= 1'b1;
    else if (wr_p1 & avs_writedata[`P1_ACK])
      low_flag_ff <= 1'b0;

  // Warning is a live level; deliberately never routed to an interrupt
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      warn_flag_ff <= 1'b0;
    else
      warn_flag_ff <= det_active & ~in_reset &                  // RULE10
                      (warn_trip_ff ? below_warn_high
                                    : below_warn_low);          // RULE11

  // Interrupt and analog control outputs, all registered
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      low_supply_irq     <= 1'b0;
      detector_on        <= 1'b0;
      detector_high_trip <= 1'b0;
      warning_high_trip  <= 1'b0;
    end
    else
    begin
      low_supply_irq     <= low_flag_ff & irq_en_ff;            // RULE9
      detector_on        <= det_active;                         // RULE2
      detector_high_trip <= det_trip_ff;                        // RULE1
      warning_high_trip  <= warn_trip_ff;                       // RULE11
    end

  ////////////////////////////////////////////////////////////////////////
  // Power modes

  // Deep stop requests fall back to clocked stop while detector stays on
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      mode_ff <= supply_wakeup_pkg::MODE_RUN;
    else if (in_reset)
      mode_ff <= supply_wakeup_pkg::MODE_RUN;
    else if (mode_ff != supply_wakeup_pkg::MODE_RUN)
    begin
      if (wake)
        mode_ff <= supply_wakeup_pkg::MODE_RUN;
    end
    else if (enter_stop)
    begin
      if ((stop_en_ff & det_en_ff) |                            // RULE3
          (stop_kind_ff == `KIND_CLOCKED))
        mode_ff <= supply_wakeup_pkg::MODE_STOP_CLK;
      else if (stop_kind_ff == `KIND_PARTIAL)
        mode_ff <= supply_wakeup_pkg::MODE_STOP_PRT;
      else
        mode_ff <= supply_wakeup_pkg::MODE_STOP_LOW;
    end
    else if (enter_wait)
      mode_ff <= supply_wakeup_pkg::MODE_WAIT;

  assign power_mode = mode_ff;

  ////////////////////////////////////////////////////////////////////////
  // Periodic wake-up timer

  // Internal oscillator stand-in: a tick enable from a divider
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      osc_div_ff  <= 8'h0;
      int_tick_ff <= 1'b0;
    end
    else if (osc_div_ff == `INT_OSC_DIV - 8'h1)
    begin
      osc_div_ff  <= 8'h0;
      int_tick_ff <= 1'b1;                                      // RULE13
    end
    else
    begin
      osc_div_ff  <= osc_div_ff + 8'h1;
      int_tick_ff <= 1'b0;
    end

  // Source choice per mode; the select bit matters only in clocked stop
  always_comb
  begin
    src_tick = 1'b0;
    case (mode_ff)
      supply_wakeup_pkg::MODE_RUN,
      supply_wakeup_pkg::MODE_WAIT:
        src_tick = external_reference_clock;                    // RULE15
      supply_wakeup_pkg::MODE_STOP_PRT:
        src_tick = int_tick_ff;                                 // RULE16
      supply_wakeup_pkg::MODE_STOP_CLK:
        src_tick = pt_src_int_ff ? int_tick_ff                  // RULE17
                 : (external_reference_clock &
                    osc_stop_ff & ~range_ff);                   // RULE18
      supply_wakeup_pkg::MODE_STOP_LOW:
        src_tick = 1'b0;                                        // RULE14
      default:
        src_tick = 1'b0;
    endcase
  end

  assign timer_tick = src_tick & (period_sel_ff != 3'h0);       // RULE21
  assign period_end = timer_tick &
                      (count_ff == period_ticks(period_sel_ff) - 16'h1);

  // Tick counter; off period select holds it cleared
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      count_ff <= 16'h0;
    else if (in_reset | (period_sel_ff == 3'h0))                // RULE21
      count_ff <= 16'h0;
    else if (period_end)
      count_ff <= 16'h0;                                        // RULE12
    else if (timer_tick)
      count_ff <= count_ff + 16'h1;

  // Timer control bits
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      period_sel_ff <= 3'h0;
      pt_irq_en_ff  <= 1'b0;
      pt_src_int_ff <= 1'b0;
    end
    else if (in_reset)
    begin
      period_sel_ff <= 3'h0;
      pt_irq_en_ff  <= 1'b0;
      pt_src_int_ff <= 1'b0;
    end
    else if (wr_pt)
    begin
      period_sel_ff <= avs_writedata[`PT_SEL_HI:`PT_SEL_LO];    // RULE19
      pt_irq_en_ff  <= avs_writedata[`PT_IRQ_EN];
      pt_src_int_ff <= avs_writedata[`PT_SRC_INT];
    end

  // Timer flag; period end beats an ack in the same cycle
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      pt_flag_ff <= 1'b0;
    else if (in_reset)
      pt_flag_ff <= 1'b0;
    else if (period_end)
      pt_flag_ff <= 1'b1;                                       // RULE23
    else if (wr_pt & avs_writedata[`PT_ACK])
      pt_flag_ff <= 1'b0;                                       // RULE22

  // Interrupt request only while the local enable is set
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      periodic_irq <= 1'b0;
    else
      periodic_irq <= pt_flag_ff & pt_irq_en_ff;                // RULE20

endmodule

// >>> testbench/supply_wakeup_properties.sv
// Port assertions for the supply monitor and wake-up timer
`timescale 1ns/1ps

module supply_wakeup_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        supply_por_ok,
  input wire logic        below_detect_high,
  input wire logic        below_detect_low,
  input wire logic        below_warn_high,
  input wire logic        below_warn_low,
  input wire logic        external_reference_clock,
  input wire logic        enter_wait,
  input wire logic        enter_stop,
  input wire logic        wake,
  input wire logic        system_reset,
  input wire logic        low_supply_irq,
  input wire logic        periodic_irq,
  input wire logic        detector_on,
  input wire logic        detector_high_trip,
  input wire logic        warning_high_trip,
  input wire logic [4:0]  power_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////
  // Bus answers after exactly one wait cycle
  AST_WAIT_ANSWER:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus request not answered");
  AST_WAIT_ONE:
    assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");

  //////////////////////////////////////////////////////////////////////////
  // Reset sequencing against the comparators
  AST_POR_HOLD:
    assert property (!supply_por_ok |=> system_reset)
      else $error("no reset under power-on level");
  AST_RELEASE:
    assert property ($fell(system_reset)
      |-> $past(supply_por_ok) && !$past(below_detect_low))
      else $error("reset released with low supply");
  // Trip select survives the hold, so a high trip keeps it held
  AST_TRIP_HOLD:
    assert property (system_reset && supply_por_ok && detector_high_trip
      && below_detect_high |=> system_reset)
      else $error("reset dropped below high trip");

  //////////////////////////////////////////////////////////////////////////
  // Power modes
  AST_DEEP_STOP:
    assert property ((power_mode[3] || power_mode[4]) [*2]
      |-> !detector_on) else $error("detector on in deep stop");
  AST_TIMER_LOWEST:
    assert property ((power_mode == 5'h10) [*2] |-> !$rose(periodic_irq))
      else $error("timer event in lowest stop");
  AST_WAKE:
    assert property (wake |=> power_mode == 5'h01)
      else $error("wake did not return to run");
  AST_ENTER_WAIT:
    assert property (enter_wait && power_mode == 5'h01 && !system_reset
      |=> power_mode == 5'h02) else $error("wait mode not entered");

  // Main scenarios reached
  cover property ($rose(low_supply_irq));
  cover property ($rose(periodic_irq));
  cover property ($fell(system_reset));
endmodule

bind supply_wakeup_ctrl supply_wakeup_checker chk (.*);

// >>> testbench/supply_model.sv
// Supply comparators and external reference tick source
`timescale 1ns/1ps

module supply_model (
  input  wire logic       ref_clk,
  input  wire logic [2:0] level,
  output logic            supply_por_ok,
  output logic            below_detect_high,
  output logic            below_detect_low,
  output logic            below_warn_high,
  output logic            below_warn_low,
  output logic            external_reference_clock
);
  // Level 0 is under power-on, 5 healthy; trips nest so no odd combos
  always_comb
  begin
    supply_por_ok     = level != 3'h0;
    below_detect_low  = level <= 3'h1;
    below_detect_high = level <= 3'h2;
    below_warn_low    = level <= 3'h3;
    below_warn_high   = level <= 3'h4;
  end

  // Reference tick every second cycle, free running like a crystal
  initial external_reference_clock = 1'b0;
  always @(posedge ref_clk)
    external_reference_clock <= !external_reference_clock;
endmodule

// >>> testbench/supply_monitor_and_periodic_wakeup_tb.sv
// Self-checking bench for the supply monitor and wake-up timer
`timescale 1ns/1ps
`include "supply_wakeup_map.svh"

module supply_monitor_and_periodic_wakeup_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        enter_wait = 1'b0;
  logic        enter_stop = 1'b0;
  logic        wake = 1'b0;
  logic [2:0]  level = 3'h0;
  logic [31:0] avs_readdata;
  logic [4:0]  power_mode;
  logic        avs_waitrequest, supply_por_ok, below_detect_high;
  logic        below_detect_low, below_warn_high, below_warn_low;
  logic        external_reference_clock, system_reset, low_supply_irq;
  logic        periodic_irq, detector_on, detector_high_trip;
  logic        warning_high_trip;
  logic [3:0]  flags;
  logic [7:0]  rd;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;

  assign flags = {system_reset, low_supply_irq, periodic_irq, detector_on};
  always #10 ref_clk = ~ref_clk;

  supply_wakeup_ctrl dut (.*);
  supply_model partner (.*);

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Request held until waitrequest is seen low; a gap edge follows
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d);
    int n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50)
      check(32'h1, 32'h0);
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check({24'h0, rd}, {24'h0, exp});
  endtask

  // Bounded wait for one of the level outputs
  task automatic await(input int i, input logic v);
    int n = 0;
    while (flags[i] !== v && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, flags[i]}, {31'h0, v});
  endtask

  // One-cycle CPU pulse: {wake, enter_wait, enter_stop}
  task automatic mode(input logic [2:0] k, input logic [4:0] exp);
    {wake, enter_wait, enter_stop} <= k;
    @(posedge ref_clk);
    {wake, enter_wait, enter_stop} <= 3'h0;
    idle(2);
    check({27'h0, power_mode}, {27'h0, exp});
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_power_on;
    await(3, 1'b1);
    wr(`OFS_POWER_ONE, 8'h05);
    level <= 3'h1;
    idle(8);
    await(3, 1'b1);
    level <= 3'h5;
    await(3, 1'b0);
    rdchk(`OFS_RESET_CAUSE, 8'h82);
    rdchk(`OFS_POWER_ONE, 8'h03);
    rdchk(5'h10, 8'h00);
    await(0, 1'b1);
  endtask

  task automatic t_timer;
    wr(`OFS_PERIODIC, 8'h01);
    idle(40);
    await(1, 1'b0);
    rdchk(`OFS_PERIODIC, 8'h81);
    wr(`OFS_PERIODIC, 8'h11);
    await(1, 1'b1);
    // Stop the clock first so a period end cannot beat the ack
    wr(`OFS_PERIODIC, 8'h10);
    wr(`OFS_PERIODIC, 8'h50);
    idle(60);
    await(1, 1'b0);
    rdchk(`OFS_PERIODIC, 8'h10);
  endtask

  task automatic t_low_irq;
    wr(`OFS_POWER_ONE, 8'h05);
    level <= 3'h2;
    idle(8);
    await(2, 1'b0);
    level <= 3'h1;
    await(2, 1'b1);
    await(3, 1'b0);
    rdchk(`OFS_POWER_ONE, 8'h85);
    level <= 3'h4;
    wr(`OFS_POWER_ONE, 8'h45);
    rdchk(`OFS_POWER_ONE, 8'h05);
    rdchk(`OFS_POWER_TWO, 8'h00);
    wr(`OFS_POWER_TWO, 8'h02);
    idle(4);
    rdchk(`OFS_POWER_TWO, 8'h82);
    await(2, 1'b0);
    level <= 3'h5;
  endtask

  task automatic t_stop;
    wr(`OFS_POWER_ONE, 8'h0b);
    wr(`OFS_POWER_TWO, 8'h20);
    mode(3'h1, 5'h04);
    await(0, 1'b1);
    mode(3'h4, 5'h01);
    mode(3'h2, 5'h02);
    mode(3'h4, 5'h01);
    wr(`OFS_POWER_ONE, 8'h01);
    mode(3'h1, 5'h10);
    idle(40);
    await(0, 1'b0);
    mode(3'h4, 5'h01);
  endtask

  task automatic t_lv_reset;
    wr(`OFS_POWER_ONE, 8'h03);
    wr(`OFS_POWER_TWO, 8'h01);
    idle(2);
    check({31'h0, detector_high_trip}, 32'h1);
    level <= 3'h2;
    await(3, 1'b1);
    rdchk(`OFS_RESET_CAUSE, 8'h82);
    idle(10);
    await(3, 1'b1);
    level <= 3'h5;
    await(3, 1'b0);
    rdchk(`OFS_POWER_ONE, 8'h03);
  endtask

  // Timer keeps running in clocked and partial stop
  task automatic t_stop_timer;
    wr(`OFS_POWER_TWO, 8'h04);
    mode(3'h1, 5'h04);
    wr(`OFS_PERIODIC, 8'h11);
    await(1, 1'b1);
    mode(3'h4, 5'h01);
    wr(`OFS_PERIODIC, 8'h50);
    wr(`OFS_POWER_TWO, 8'h10);
    mode(3'h1, 5'h08);
    // Internal source is slow: eight ticks of fifty cycles each
    wr(`OFS_PERIODIC, 8'h11);
    idle(300);
    await(1, 1'b1);
    mode(3'h4, 5'h01);
    wr(`OFS_PERIODIC, 8'h50);
    await(1, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run is under a thousand cycles; this only cuts a hang
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      results();
    end
  end

  initial
  begin
    idle(10);
    rst <= 1'b0;
    t_power_on();
    t_timer();
    t_low_irq();
    t_stop();
    t_lv_reset();
    t_stop_timer();
    results();
  end
endmodule
